// file: memtype_map.svh
`ifndef MEMTYPE_MAP_SVH
`define MEMTYPE_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets on the Avalon slave
// ----------------------------------------------------------------
`define ADDR_W            5
`define OFS_CTRL          5'h00
`define OFS_MISC          5'h04
`define OFS_PTT_LO        5'h08
`define OFS_PTT_HI        5'h0C
`define OFS_STATUS        5'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_CD_BIT       0
`define CTRL_NW_BIT       1
`define CTRL_RANGE_EN_BIT 2
`define CTRL_CD_FORCE_BIT 3
`define MISC_L3_DIS_BIT   6
`define PTT_ENTRY_W       8
`define PTT_LO_ENTRIES    4
`define STAT_TYPE_LSB     0
`define STAT_LOOKUP_BIT   4
`define STAT_PAGE_UC_BIT  5
`define STAT_FILL_BIT     6
`define STAT_DUP_BIT      7
`define STAT_NORMAL_BIT   8
`define STAT_L3_BIT       9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTRL_RESET        32'h00000003
`define MISC_RESET        32'h00000000
`define PTT_RESET         32'h06060606
`define STATUS_RESET      32'h00000000
`define ZERO_WORD         32'h00000000

`endif

// file: memtype_pkg.sv
`default_nettype none
package memtype_pkg;

  // Memory type codes; codes 2 and 3 are unused and resolve as strongly uncached.
  typedef enum logic [2:0] {
    STRONG_UNCACHEABLE = 3'h0,
    WRITE_COMBINING    = 3'h1,
    WRITE_THROUGH      = 3'h4,
    WRITE_PROTECT      = 3'h5,
    WRITE_BACK         = 3'h6,
    WEAK_UNCACHEABLE   = 3'h7
  } mem_type_type;

  // One access presented for typing.
  typedef struct packed {
    logic       valid;
    logic [2:0] range_type;
    logic       table_select_bit;
    logic       page_cache_disable_bit;
    logic       page_write_through_bit;
    logic       is_write;
    logic       straddle;
    logic [2:0] second_index;
  } access_req_type;

  // Typing answer for the cache.
  typedef struct packed {
    logic         valid;
    mem_type_type eff_type;
    logic         lookup_required;
    logic         page_uc_lookup;
    logic         strict_order;
    logic         fill_allow;
    logic         l3_lookup;
    logic         l3_alloc;
    logic         dup_write;
  } access_res_type;

endpackage : memtype_pkg
`default_nettype wire

// file: effective_memory_type_resolver.sv
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "memtype_map.svh"

// Notes on behaviour
// - Resolve types in every mode unless forced uncached.
// - Page type indexed by select, disable, through.
// - Range strong uncached: only combining escapes.
// - Range combining: table row as listed.
// - Range write-through: table row as listed.
// - Range write-back passes page, weak uncached as strong; protect row.
// - Range-sourced strong uncached needs no snoop.
// - Page-sourced strong uncached still looks up.
// - Straddling writes across types may duplicate.
// - No-fill mode keeps serving valid hits.
// - Disabled ranges type strong uncached; combining pages still escape.
// - Optional: disable flag alone forces uncached.
// - Third-level disable bit six, independent.
// - Third level ignores other controls when disabled.
module effective_memory_type_resolver (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_b,
  input  wire logic [`ADDR_W-1:0]          avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire memtype_pkg::access_req_type access_req,
  output memtype_pkg::access_res_type      access_res
);
  import memtype_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Unused codes are typed as strongly uncached, the safe reading.
  function automatic mem_type_type to_type(input logic [2:0] code);
    case (code)
      3'h1:    to_type = WRITE_COMBINING;
      3'h4:    to_type = WRITE_THROUGH;
      3'h5:    to_type = WRITE_PROTECT;
      3'h6:    to_type = WRITE_BACK;
      3'h7:    to_type = WEAK_UNCACHEABLE;
      default: to_type = STRONG_UNCACHEABLE;
    endcase
  endfunction : to_type

  // Picks one eight-bit table entry; low three bits carry the type.
  function automatic mem_type_type entry_of(input logic [31:0] lo,
                                            input logic [31:0] hi,
                                            input logic [2:0]  idx);
    logic [31:0] word;
    logic [1:0]  lane;
    word = idx[2] ? hi : lo;
    lane = idx[1:0];
    entry_of = to_type(word[lane*`PTT_ENTRY_W +: 3]);
  endfunction : entry_of

  // Range type by page type merge.
  function automatic mem_type_type resolve(input mem_type_type rng,
                                           input mem_type_type pg);
    resolve = STRONG_UNCACHEABLE;
    case (rng)
      STRONG_UNCACHEABLE: begin
        resolve = (pg == WRITE_COMBINING) ? WRITE_COMBINING : STRONG_UNCACHEABLE;
      end
      WRITE_COMBINING: begin
        if (pg == WEAK_UNCACHEABLE || pg == WRITE_COMBINING || pg == WRITE_BACK) begin
          resolve = WRITE_COMBINING;
        end else begin
          resolve = STRONG_UNCACHEABLE;
        end
      end
      WRITE_THROUGH: begin
        case (pg)
          WRITE_COMBINING: resolve = WRITE_COMBINING;
          WRITE_THROUGH:   resolve = WRITE_THROUGH;
          WRITE_BACK:      resolve = WRITE_THROUGH;
          default:         resolve = STRONG_UNCACHEABLE;
        endcase
      end
      WRITE_BACK: begin
        resolve = (pg == WEAK_UNCACHEABLE) ? STRONG_UNCACHEABLE : pg;
      end
      WRITE_PROTECT: begin
        case (pg)
          STRONG_UNCACHEABLE: resolve = STRONG_UNCACHEABLE;
          WRITE_COMBINING:    resolve = WRITE_COMBINING;
          WRITE_THROUGH:      resolve = WRITE_THROUGH;
          WEAK_UNCACHEABLE:   resolve = WRITE_COMBINING;
          default:            resolve = WRITE_PROTECT;
        endcase
      end
      default: resolve = STRONG_UNCACHEABLE;
    endcase
  endfunction : resolve

  // Byte-lane merge of a bus write.
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  be);
    merge = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
  endfunction : merge

  // Only these three types may allocate lines; combining and both
  // uncached kinds always bypass fills.
  function automatic logic cacheable(input mem_type_type t);
    cacheable = (t == WRITE_THROUGH) || (t == WRITE_PROTECT) || (t == WRITE_BACK);
  endfunction : cacheable

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Software-visible state first, then the combinational typing nets that
  // feed the registered answer and the status word.
  logic [31:0]    ctrl_reg;
  logic [31:0]    misc_reg;
  logic [31:0]    ptt_lo_reg;
  logic [31:0]    ptt_hi_reg;
  logic [31:0]    status_reg;
  logic [31:0]    status_next;
  logic [31:0]    rdata_next;
  logic           wait_reg;
  logic           wr_take;
  logic           normal_mode;
  logic           range_en;
  logic           cd_force;
  logic           l3_dis;
  mem_type_type   range_t;
  mem_type_type   page_t;
  mem_type_type   page2_t;
  mem_type_type   merged_t;
  mem_type_type   merged2_t;
  mem_type_type   eff_next;
  logic           range_uc;
  logic           lookup_next;
  logic           page_uc_next;
  logic           fill_next;
  logic           dup_next;
  access_res_type res_next;

  // Write lands only at the edge where waitrequest is seen low.
  assign wr_take = avs_write && !wait_reg;

  // ----------------------------------------------------------------
  // Avalon handshake
  // ----------------------------------------------------------------

  // Every access waits exactly one cycle, so the answer is fixed.
  // Waitrequest idles high; this costs a cycle per access but lets read
  // data leave a flop without a second decode stage.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wait_reg <= 1'b1;
    end else if ((avs_read || avs_write) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Read data is captured while waiting and stands in the answer cycle.
  always_comb begin
    case (avs_address)
      `OFS_CTRL:   rdata_next = ctrl_reg;
      `OFS_MISC:   rdata_next = misc_reg;
      `OFS_PTT_LO: rdata_next = ptt_lo_reg;
      `OFS_PTT_HI: rdata_next = ptt_hi_reg;
      `OFS_STATUS: rdata_next = status_reg;
      default:     rdata_next = `ZERO_WORD;
    endcase
  end

  // Read data is only loaded on the edge that sees a read with waitrequest high, so it holds between reads
  // and a master that samples late still sees the same word.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      avs_readdata <= `ZERO_WORD;
    end else if (avs_read && wait_reg) begin
      avs_readdata <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Control and table registers
  // ----------------------------------------------------------------

  // Unmapped and status writes are dropped without error.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_reg   <= `CTRL_RESET;
      misc_reg   <= `MISC_RESET;
      ptt_lo_reg <= `PTT_RESET;
      ptt_hi_reg <= `PTT_RESET;
    end else if (wr_take) begin
      case (avs_address)
        `OFS_CTRL:   ctrl_reg   <= merge(ctrl_reg, avs_writedata, avs_byteenable);
        `OFS_MISC:   misc_reg   <= merge(misc_reg, avs_writedata, avs_byteenable);
        `OFS_PTT_LO: ptt_lo_reg <= merge(ptt_lo_reg, avs_writedata, avs_byteenable);
        `OFS_PTT_HI: ptt_hi_reg <= merge(ptt_hi_reg, avs_writedata, avs_byteenable);
        default:     ctrl_reg   <= ctrl_reg;
      endcase
    end
  end

  // Mode bits are read straight from the registers, so a new setting types
  // the very next access after the write lands.
  assign range_en = ctrl_reg[`CTRL_RANGE_EN_BIT];
  assign cd_force = ctrl_reg[`CTRL_CD_FORCE_BIT];
  assign l3_dis   = misc_reg[`MISC_L3_DIS_BIT];

  assign normal_mode = !ctrl_reg[`CTRL_CD_BIT] && !ctrl_reg[`CTRL_NW_BIT];

  // ----------------------------------------------------------------
  // Type resolution
  // ----------------------------------------------------------------

  // disabled ranges give all memory a strongly uncached range type
  assign range_t = range_en ? to_type(access_req.range_type) : STRONG_UNCACHEABLE;

  // three page bits index the table
  assign page_t  = entry_of(ptt_lo_reg, ptt_hi_reg,
                            {access_req.table_select_bit,
                             access_req.page_cache_disable_bit,
                             access_req.page_write_through_bit});
  assign page2_t = entry_of(ptt_lo_reg, ptt_hi_reg, access_req.second_index);

  // The second page is merged with the same range type, since a straddle
  // is assumed to stay within one physical range.
  assign merged_t  = resolve(range_t, page_t);
  assign merged2_t = resolve(range_t, page2_t);
  assign range_uc  = (range_t == STRONG_UNCACHEABLE) && (merged_t == STRONG_UNCACHEABLE);

  // Outside normal caching the table still types accesses unless the
  // forcing option is set; fills stop either way.
  always_comb begin
    eff_next     = merged_t;
    lookup_next  = 1'b1;
    page_uc_next = 1'b0;
    fill_next    = 1'b0;
    if (normal_mode) begin
      lookup_next  = !range_uc;
      page_uc_next = (merged_t == STRONG_UNCACHEABLE) && !range_uc;
      fill_next    = cacheable(merged_t);
    end else if (cd_force) begin
      eff_next     = STRONG_UNCACHEABLE;
      page_uc_next = 1'b1;
    end else if (merged_t == STRONG_UNCACHEABLE) begin
      page_uc_next = !range_uc;
    end
    // lookup stays on in no-fill mode
    if (!normal_mode) begin
      lookup_next = 1'b1;
    end
  end

  // Outside normal caching no split by type is reported, since every
  // access then behaves alike towards memory.
  // straddling write over differing types
  assign dup_next = access_req.is_write && access_req.straddle && normal_mode &&
                    (merged2_t != merged_t);

  // third level follows its own disable bit
  // disabled third level ignores other controls
  // The third-level gates sit last so that no lower-level control can
  // reopen a disabled third level.
  always_comb begin
    res_next                 = '0;
    res_next.valid           = access_req.valid;
    res_next.eff_type        = eff_next;
    res_next.lookup_required = lookup_next;
    res_next.page_uc_lookup  = page_uc_next;
    res_next.strict_order    = (eff_next == STRONG_UNCACHEABLE);
    res_next.fill_allow      = fill_next;
    res_next.l3_lookup       = !l3_dis && lookup_next;
    res_next.l3_alloc        = !l3_dis && fill_next;
    res_next.dup_write       = dup_next;
  end

  // ----------------------------------------------------------------
  // Registered answer and status
  // ----------------------------------------------------------------

  // The answer is one cycle behind the request so it leaves a flop.
  // Fields are computed even for idle cycles; only valid qualifies them.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      access_res <= '0;
    end else begin
      access_res <= res_next;
    end
  end

  // Status shows the most recent valid access and the live mode.
  always_comb begin
    status_next = status_reg;
    if (access_req.valid) begin
      status_next[`STAT_TYPE_LSB +: 3] = eff_next;
      status_next[`STAT_LOOKUP_BIT]    = lookup_next;
      status_next[`STAT_PAGE_UC_BIT]   = page_uc_next;
      status_next[`STAT_FILL_BIT]      = fill_next;
      status_next[`STAT_DUP_BIT]       = dup_next;
    end
    status_next[`STAT_NORMAL_BIT] = normal_mode;
    status_next[`STAT_L3_BIT]     = !l3_dis;
  end

  // Status is rewritten every cycle so the live mode bits never go stale.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      status_reg <= `STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Waitrequest is the handshake flop itself, with no logic after it.
  assign avs_waitrequest = wait_reg;

endmodule : effective_memory_type_resolver

`default_nettype wire

// file: effective_memory_type_resolver_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the memory type resolver
// ----------------------------------------------------------------
module effective_memory_type_resolver_chk (
  input wire logic                        clk_sys,
  input wire logic                        rst_b,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic                        avs_waitrequest,
  input wire memtype_pkg::access_req_type access_req,
  input wire memtype_pkg::access_res_type access_res
);
  import memtype_pkg::*;

  // All checks share the one clock, and reset switches them off.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // A taken bus request is answered one cycle later, and only for one cycle.
  a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer longer than one cycle");
  // Each typing answer stands exactly one cycle behind its request.
  a_result_follows: assert property (1'b1 |=> access_res.valid == $past(access_req.valid))
    else $error("typing answer not one cycle behind request");
  a_uc_range_row: assert property (access_req.valid && access_req.range_type == 3'h0 |=>
    access_res.eff_type inside {STRONG_UNCACHEABLE, WRITE_COMBINING})
    else $error("uncached range gave a cacheable type");
  a_no_snoop_uc: assert property (access_res.valid && !access_res.lookup_required |->
    access_res.eff_type == STRONG_UNCACHEABLE && !access_res.page_uc_lookup)
    else $error("lookup skipped for a non range uncached result");
  a_page_uc_look: assert property (access_res.valid && access_res.page_uc_lookup |->
    access_res.lookup_required && access_res.strict_order)
    else $error("page uncached result without lookup");
  a_strict_uc: assert property (access_res.valid |->
    access_res.strict_order == (access_res.eff_type == STRONG_UNCACHEABLE))
    else $error("strict order disagrees with type");
  a_fill_cacheable: assert property (access_res.fill_allow |->
    access_res.eff_type inside {WRITE_THROUGH, WRITE_PROTECT, WRITE_BACK})
    else $error("fill allowed for a non cacheable type");
  a_l3_gated: assert property (access_res.l3_alloc |->
    access_res.fill_allow && access_res.l3_lookup)
    else $error("third level allocates without fill");
  a_dup_cause: assert property (access_req.valid && !(access_req.is_write && access_req.straddle)
    |=> !access_res.dup_write)
    else $error("duplicate write flag without straddling write");
endmodule : effective_memory_type_resolver_chk

bind effective_memory_type_resolver effective_memory_type_resolver_chk chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .access_req(access_req), .access_res(access_res));
`default_nettype wire

// file: test_effective_memory_type_resolver.sv
`timescale 1ns/1ps
`default_nettype none
`include "memtype_map.svh"
// ----------------------------------------------------------------
// Bench for the memory type resolver
// ----------------------------------------------------------------
module test_effective_memory_type_resolver;
  import memtype_pkg::*;
  logic                 clk_sys = 1'b0;
  logic                 rst_b = 1'b0;
  logic [`ADDR_W-1:0]   avs_address = 5'h00;
  logic                 avs_read = 1'b0;
  logic                 avs_write = 1'b0;
  logic [31:0]          avs_writedata = 32'h0;
  logic [3:0]           avs_byteenable = 4'hF;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  access_req_type       access_req = '0;
  access_res_type       access_res;
  access_res_type       acc_q[$];
  logic [31:0]          rd_q[$];
  logic [31:0]          sh[4] = '{32'h3, 32'h0, 32'h06060606, 32'h06060606};
  logic [2:0]           rtab[5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
  logic [7:0]           last_stat = 8'h00;
  int                   mismatches = 0;
  int                   total_checks = 0;
  int                   cycles = 0;
  int                   seed = 48761;

  effective_memory_type_resolver dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .access_req(access_req), .access_res(access_res));

  // The clock toggles every half period of 12.5 ns.
  always #12.5 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // One bus access, held until the edge that sees waitrequest low.
  task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= rd;
    avs_write      <= !rd;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    for (int b = 0; b < 4; b++)
      if (be[b] && a < 5'h10) sh[a[3:2]][b*8 +: 8] = d[b*8 +: 8];
    bus(1'b0, a, d, be);
  endtask : wr

  // Status expects the latest valid access and the live mode bits.
  task automatic rd(input logic [4:0] a);
    if (a == 5'h10)
      rd_q.push_back({22'h0, !sh[1][6], sh[0][1:0] == 2'b00, last_stat});
    else
      rd_q.push_back(a < 5'h10 ? sh[a[3:2]] : 32'h0);
    bus(1'b1, a, 32'h0, 4'hF);
  endtask : rd

  function automatic mem_type_type resolve(input logic [2:0] r, input logic [2:0] p);
    case (r)
      3'h1: return (p inside {3'h0, 3'h4, 3'h5}) ? STRONG_UNCACHEABLE : WRITE_COMBINING;
      3'h4: return (p == 3'h1) ? WRITE_COMBINING :
                   (p inside {3'h4, 3'h6}) ? WRITE_THROUGH : STRONG_UNCACHEABLE;
      3'h5: return (p == 3'h7) ? WRITE_COMBINING : (p == 3'h6) ? WRITE_PROTECT : mem_type_type'(p);
      3'h6: return (p == 3'h7) ? STRONG_UNCACHEABLE : mem_type_type'(p);
      default: return (p == 3'h1) ? WRITE_COMBINING : STRONG_UNCACHEABLE;
    endcase
  endfunction : resolve

  function automatic logic [2:0] page_of(input logic [2:0] i);
    return sh[2 + i[2]][{i[1:0], 3'b000} +: 3];
  endfunction : page_of

  function automatic access_res_type expect_of(input access_req_type q);
    access_res_type e;
    logic           normal;
    logic [2:0]     rt;
    normal = sh[0][1:0] == 2'b00;
    rt = sh[0][2] ? q.range_type : 3'h0;
    e = '0;
    e.valid = q.valid;
    e.eff_type = resolve(rt, page_of({q.table_select_bit, q.page_cache_disable_bit,
                                      q.page_write_through_bit}));
    if (!normal && sh[0][3]) e.eff_type = STRONG_UNCACHEABLE;
    e.strict_order = e.eff_type == STRONG_UNCACHEABLE;
    e.lookup_required = !normal || !(rt == 3'h0 && e.strict_order);
    e.page_uc_lookup = e.strict_order && (rt != 3'h0 || (!normal && sh[0][3]));
    e.fill_allow = normal && e.eff_type inside {WRITE_THROUGH, WRITE_PROTECT, WRITE_BACK};
    e.l3_lookup = e.lookup_required && !sh[1][6];
    e.l3_alloc = e.fill_allow && !sh[1][6];
    e.dup_write = normal && q.is_write && q.straddle &&
                  resolve(rt, page_of(q.second_index)) != e.eff_type;
    return e;
  endfunction : expect_of

  // Back-to-back accesses; a sweep walks every range row and table index.
  task automatic burst(input int n, input bit sweep);
    access_req_type q;
    access_res_type e;
    for (int i = 0; i < n; i++) begin
      q = 12'($random(seed));
      q.valid = 1'b1;
      q.range_type = rtab[sweep ? i / 8 : $unsigned($random(seed)) % 5];
      if (sweep) {q.table_select_bit, q.page_cache_disable_bit, q.page_write_through_bit} = 3'(i);
      @(posedge clk_sys);
      access_req <= q;
      e = expect_of(q);
      acc_q.push_back(e);
      last_stat = {e.dup_write, e.fill_allow, e.page_uc_lookup, e.lookup_required, 1'b0,
                   e.eff_type};
    end
    @(posedge clk_sys);
    access_req <= '0;
  endtask : burst

  // Watcher: takes the oldest note whenever a result or read data appears.
  always @(posedge clk_sys) begin
    if (rst_b && access_res.valid === 1'b1)
      check("result", 32'(access_res), 32'(acc_q.size() ? acc_q.pop_front() : '0));
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      check("readdata", avs_readdata, rd_q.pop_front());
  end

  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int k = 0; k < 6; k++)
      rd(5'(k * 4));
    wr(5'h08, 32'h04010700, 4'hF);
    wr(5'h0C, 32'hFFFF0506, 4'h3);
    wr(5'h14, 32'hFFFFFFFF, 4'hF);
    wr(5'h00, 32'h4, 4'hF);
    rd(5'h08);
    rd(5'h0C);
    rd(5'h00);
    burst(40, 1'b1);
    rd(5'h10);
    wr(5'h00, 32'h5, 4'hF);
    burst(16, 1'b0);
    rd(5'h10);
    wr(5'h00, 32'h1, 4'hF);
    burst(16, 1'b0);
    wr(5'h00, 32'h9, 4'hF);
    burst(16, 1'b0);
    wr(5'h04, 32'h40, 4'hF);
    rd(5'h04);
    wr(5'h00, 32'h4, 4'hF);
    burst(16, 1'b0);
    rd(5'h10);
    wr(5'h00, 32'h0, 4'hF);
    burst(16, 1'b0);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    sh = '{32'h3, 32'h0, 32'h06060606, 32'h06060606};
    last_stat = 8'h00;
    rd(5'h00);
    rd(5'h04);
    rd(5'h10);
    repeat (3) @(posedge clk_sys);
    check("pending results", 32'(acc_q.size()), 32'h0);
    tally_and_finish();
  end
endmodule : test_effective_memory_type_resolver
`default_nettype wire
